// ### rtl/apf_port_flags.sv
// Address port enables, source/target/last-walk flags and APB registers
`default_nettype none
`include "apf_map.svh"
module apf_port_flags (
	input wire logic sys_clk_i, // System clock, 125 MHz
	input wire logic rst_i, // Async reset, active high
	input wire logic [7:0] paddr_i, // APB address
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB direction
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error, unmapped address
	input wire logic src_port_oe_n_i, // Source port enable pin
	input wire logic coef_port_oe_n_i, // Coefficient port enable pin
	input wire logic tgt_port_oe_n_i, // Target port enable pin
	input wire logic [23:0] source_address_i, // Source address from core
	input wire logic [7:0] coefficient_address_i, // Coef address from core
	input wire logic [11:0] target_address_i, // Target address from core
	input wire logic target_write_n_i, // Target write strobe from core
	input wire logic [23:0] src_coord_i, // Own source component
	input wire logic [11:0] tgt_col_i, // Current target column
	input wire logic [11:0] tgt_row_i, // Current target row
	input wire logic [11:0] tgt_page_i, // Current target page
	input wire logic walk_last_i, // Last walk of own dimension
	output logic [23:0] source_address_o, // Source address pin
	output logic source_address_oe_o, // Source pin drive enable
	output logic [7:0] coefficient_address_o, // Coef address pin
	output logic coefficient_address_oe_o, // Coef pin drive enable
	output logic [11:0] target_address_o, // Target address pin
	output logic target_address_oe_o, // Target pin drive enable
	output logic target_write_n_o, // Target write strobe pin
	output logic target_write_oe_o, // Strobe pin drive enable
	output logic source_in_range_n_o, // Source valid flag, active low
	output logic target_in_window_n_o, // Target valid flag, active low
	output logic dimension_last_walk_o, // Last walk flag
	output logic irq_o // Interrupt, level
);
	logic three_d_reg;
	apf_pkg::apf_dim_t dim_reg;
	apf_pkg::apf_delay_t source_flag_delay_reg;
	apf_pkg::apf_delay_t target_flag_delay_reg;
	apf_pkg::apf_delay_t last_walk_flag_delay_reg;
	apf_pkg::apf_src_addr_t src_lower_reg [0:2];
	apf_pkg::apf_src_addr_t src_upper_reg [0:2];
	apf_pkg::apf_tgt_addr_t win_lower_reg [0:2];
	apf_pkg::apf_tgt_addr_t win_upper_reg [0:2];
	logic [2:0] win_inside;
	logic [2:0] src_hit;
	logic [2:0] win_hit;
	logic [2:0] src_inside_dim;
	logic src_inside;
	logic tgt_inside;
	logic src_nom_reg;
	logic tgt_nom_reg;
	logic end_nom_reg;
	logic [23:0] source_address_reg;
	logic [7:0] coefficient_address_reg;
	logic [11:0] target_address_reg;
	logic target_write_n_reg;
	logic [2:0] flags;
	logic [2:0] flags_prev_reg;
	logic [2:0] irq_event;
	logic [2:0] irq_status_reg;
	logic [2:0] irq_mask_reg;
	logic [2:0] rd_clear_reg;
	logic [31:0] rd_data;
	logic addr_hit;
	logic setup_rd;
	logic access_wr;
	logic access_rd;
	logic [31:0] prdata_reg;

	// Enables bypass the clock entirely so the pins float at once
	assign source_address_oe_o = ~src_port_oe_n_i;
	assign coefficient_address_oe_o = ~coef_port_oe_n_i;
	// No addressing mode term on purpose: one enable for both modes
	assign target_address_oe_o = ~tgt_port_oe_n_i;
	assign target_write_oe_o = ~tgt_port_oe_n_i;
	assign source_address_o = source_address_reg;
	assign coefficient_address_o = coefficient_address_reg;
	assign target_address_o = target_address_reg;
	assign target_write_n_o = target_write_n_reg;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			source_address_reg <= 24'h000000;
			coefficient_address_reg <= 8'h00;
			target_address_reg <= 12'h000;
			target_write_n_reg <= 1'b1;
		end else begin
			source_address_reg <= source_address_i;
			coefficient_address_reg <= coefficient_address_i;
			target_address_reg <= target_address_i;
			target_write_n_reg <= target_write_n_i;
		end
	end

	assign setup_rd = psel_i & ~penable_i & ~pwrite_i;
	assign access_wr = psel_i & penable_i & pwrite_i & addr_hit;
	assign access_rd = psel_i & penable_i & ~pwrite_i;

	// Per-dimension bounds, source compare and register slots
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_dim
			localparam logic [7:0] LO_OFS =
				8'(`APF_OFS_SRC_BASE + `APF_SRC_STRIDE * gi);
			localparam logic [7:0] HI_OFS = 8'(LO_OFS + 8'h04);
			localparam logic [7:0] WIN_OFS =
				8'(`APF_OFS_WIN_BASE + `APF_WIN_STRIDE * gi);
			assign src_hit[gi] = (paddr_i == LO_OFS) || (paddr_i == HI_OFS);
			assign win_hit[gi] = (paddr_i == WIN_OFS);
			always_ff @(posedge sys_clk_i or posedge rst_i) begin
				if (rst_i) begin
					src_lower_reg[gi] <= `APF_BOUND_RST;
					src_upper_reg[gi] <= `APF_BOUND_RST;
					win_lower_reg[gi] <= `APF_WIN_RST;
					win_upper_reg[gi] <= `APF_WIN_RST;
				end else if (access_wr) begin
					if (paddr_i == LO_OFS) begin
						src_lower_reg[gi] <= pwdata_i[23:0];
					end
					if (paddr_i == HI_OFS) begin
						src_upper_reg[gi] <= pwdata_i[23:0];
					end
					// Own window per device
					if (paddr_i == WIN_OFS) begin
						win_lower_reg[gi] <=
							pwdata_i[`APF_WIN_LO_LSB +: 12];
						win_upper_reg[gi] <=
							pwdata_i[`APF_WIN_HI_LSB +: 12];
					end
				end
			end
			apf_range_check #(.W(24)) u_src_chk (
				.value_i(src_coord_i),
				.lower_i(src_lower_reg[gi]),
				.upper_i(src_upper_reg[gi]),
				.inside_o(src_inside_dim[gi])
			);
		end
	endgenerate

	// Unsigned 12-bit window compares
	apf_range_check #(.W(12)) u_win_col (
		.value_i(tgt_col_i),
		.lower_i(win_lower_reg[0]),
		.upper_i(win_upper_reg[0]),
		.inside_o(win_inside[0])
	);
	apf_range_check #(.W(12)) u_win_row (
		.value_i(tgt_row_i),
		.lower_i(win_lower_reg[1]),
		.upper_i(win_upper_reg[1]),
		.inside_o(win_inside[1])
	);
	apf_range_check #(.W(12)) u_win_page (
		.value_i(tgt_page_i),
		.lower_i(win_lower_reg[2]),
		.upper_i(win_upper_reg[2]),
		.inside_o(win_inside[2])
	);

	always_comb begin
		case (dim_reg)
			apf_pkg::APF_DIM_ROW: src_inside = src_inside_dim[1];
			apf_pkg::APF_DIM_PAGE: src_inside = src_inside_dim[2];
			default: src_inside = src_inside_dim[0];
		endcase
	end

	// Page bounds only matter for volume images
	assign tgt_inside = win_inside[0] & win_inside[1] &
		(~three_d_reg | win_inside[2]);

	// Nominal flags land with the addresses they describe
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			src_nom_reg <= 1'b1;
			tgt_nom_reg <= 1'b1;
			end_nom_reg <= 1'b0;
		end else begin
			src_nom_reg <= ~src_inside;
			tgt_nom_reg <= ~tgt_inside;
			end_nom_reg <= walk_last_i;
		end
	end

	apf_flag_delay #(.RST_VAL(1'b1)) u_src_dly (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.d_i(src_nom_reg),
		.sel_i(source_flag_delay_reg),
		.q_o(source_in_range_n_o)
	);
	apf_flag_delay #(.RST_VAL(1'b1)) u_tgt_dly (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.d_i(tgt_nom_reg),
		.sel_i(target_flag_delay_reg),
		.q_o(target_in_window_n_o)
	);
	apf_flag_delay #(.RST_VAL(1'b0)) u_end_dly (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.d_i(end_nom_reg),
		.sel_i(last_walk_flag_delay_reg),
		.q_o(dimension_last_walk_o)
	);

	assign flags[`APF_FLAG_SRC_BIT] = source_in_range_n_o;
	assign flags[`APF_FLAG_TGT_BIT] = target_in_window_n_o;
	assign flags[`APF_FLAG_END_BIT] = dimension_last_walk_o;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			three_d_reg <= 1'b0;
			dim_reg <= apf_pkg::APF_DIM_COL;
			source_flag_delay_reg <= 3'h0;
			target_flag_delay_reg <= 3'h0;
			last_walk_flag_delay_reg <= 3'h0;
			irq_mask_reg <= 3'h0;
		end else if (access_wr) begin
			if (paddr_i == `APF_OFS_CTRL) begin
				three_d_reg <= pwdata_i[`APF_CTRL_3D_BIT];
				dim_reg <= apf_pkg::apf_dim_t'(
					pwdata_i[`APF_CTRL_DIM_LSB +: 2]);
				source_flag_delay_reg <= pwdata_i[`APF_CTRL_SDLY_LSB +: 3];
				target_flag_delay_reg <= pwdata_i[`APF_CTRL_TDLY_LSB +: 3];
				last_walk_flag_delay_reg <=
					pwdata_i[`APF_CTRL_EDLY_LSB +: 3];
			end
			if (paddr_i == `APF_OFS_IRQ_MASK) begin
				irq_mask_reg <= pwdata_i[2:0];
			end
		end
	end

	// Events are rising edges of the flags as they leave the pins
	assign irq_event = flags & ~flags_prev_reg;

	// Clear only what the read returned, and a new event wins
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			// Idle flag levels, so leaving reset is no event
			flags_prev_reg <= 3'h3;
			irq_status_reg <= 3'h0;
		end else begin
			flags_prev_reg <= flags;
			if (access_rd && paddr_i == `APF_OFS_IRQ_STATUS) begin
				irq_status_reg <= (irq_status_reg & ~rd_clear_reg) |
					irq_event;
			end else begin
				irq_status_reg <= irq_status_reg | irq_event;
			end
		end
	end

	assign irq_o = |(irq_status_reg & irq_mask_reg);

	always_comb begin
		rd_data = 32'h00000000;
		addr_hit = 1'b1;
		case (paddr_i)
			`APF_OFS_CTRL: begin
				rd_data[`APF_CTRL_3D_BIT] = three_d_reg;
				rd_data[`APF_CTRL_DIM_LSB +: 2] = dim_reg;
				rd_data[`APF_CTRL_SDLY_LSB +: 3] = source_flag_delay_reg;
				rd_data[`APF_CTRL_TDLY_LSB +: 3] = target_flag_delay_reg;
				rd_data[`APF_CTRL_EDLY_LSB +: 3] = last_walk_flag_delay_reg;
			end
			`APF_OFS_FLAGS: rd_data[2:0] = flags;
			`APF_OFS_IRQ_STATUS: rd_data[2:0] = irq_status_reg;
			`APF_OFS_IRQ_MASK: rd_data[2:0] = irq_mask_reg;
			default: begin
				addr_hit = |src_hit | |win_hit;
				for (int i = 0; i < 3; i++) begin
					if (paddr_i == 8'(`APF_OFS_SRC_BASE +
						`APF_SRC_STRIDE * i)) begin
						rd_data[23:0] = src_lower_reg[i];
					end else if (paddr_i == 8'(`APF_OFS_SRC_BASE +
						`APF_SRC_STRIDE * i + 4)) begin
						rd_data[23:0] = src_upper_reg[i];
					end else if (win_hit[i]) begin
						rd_data[`APF_WIN_LO_LSB +: 12] = win_lower_reg[i];
						rd_data[`APF_WIN_HI_LSB +: 12] = win_upper_reg[i];
					end
				end
			end
		endcase
	end

	// Read data is caught in setup so the access phase needs no wait
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_reg <= 32'h00000000;
			rd_clear_reg <= 3'h0;
		end else if (setup_rd) begin
			prdata_reg <= rd_data;
			rd_clear_reg <= (paddr_i == `APF_OFS_IRQ_STATUS) ?
				irq_status_reg : 3'h0;
		end
	end

	assign prdata_o = prdata_reg;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~addr_hit;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	AST_SRC_PORT_FLOAT: assert property (
		src_port_oe_n_i |-> !source_address_oe_o)
		else $error("source port driven while disabled");
	AST_COEF_PORT_FLOAT: assert property (
		coef_port_oe_n_i |-> !coefficient_address_oe_o)
		else $error("coefficient port driven while disabled");
	AST_TGT_PAIR_OE: assert property (
		(target_address_oe_o == target_write_oe_o) &&
		(target_write_oe_o == !tgt_port_oe_n_i))
		else $error("target enables disagree");
	AST_SRC_FLAG_NOMINAL: assert property (
		(source_flag_delay_reg == 3'h0 && !rst_i)[*2] |->
		source_in_range_n_o == !$past(src_inside))
		else $error("source flag not in nominal cycle");
	AST_SRC_FLAG_DELAY7: assert property (
		(source_flag_delay_reg == 3'h7)[*8] |->
		source_in_range_n_o == $past(src_nom_reg, 7))
		else $error("source flag delay of seven wrong");
	AST_TGT_FLAG_NOMINAL: assert property (
		(target_flag_delay_reg == 3'h0 && !rst_i)[*2] |->
		target_in_window_n_o == !$past(tgt_inside))
		else $error("target flag not in nominal cycle");
	AST_TGT_FLAG_DELAY2: assert property (
		(target_flag_delay_reg == 3'h2)[*3] |->
		target_in_window_n_o == $past(tgt_nom_reg, 2))
		else $error("target flag delay of two wrong");
	AST_END_NOMINAL: assert property (
		(last_walk_flag_delay_reg == 3'h0)[*2] |->
		dimension_last_walk_o == $past(walk_last_i))
		else $error("last walk flag not nominal");
	AST_END_DELAY5: assert property (
		(last_walk_flag_delay_reg == 3'h5)[*6] |->
		dimension_last_walk_o == $past(end_nom_reg, 5))
		else $error("last walk flag delay of five wrong");
	AST_SRC_EVENT_STICKY: assert property (
		$rose(source_in_range_n_o) |=> irq_status_reg[0])
		else $error("source event not recorded");

	COV_SRC_LEAVES: cover property ($rose(source_in_range_n_o));
	COV_TGT_LEAVES: cover property ($rose(target_in_window_n_o));
	COV_LAST_WALK: cover property ($rose(dimension_last_walk_o));
	COV_IRQ: cover property ($rose(irq_o));
endmodule
`default_nettype wire

// ### rtl/apf_map.svh
// Register offsets, field positions and reset values of the port/flag block
`ifndef APF_MAP_SVH
`define APF_MAP_SVH

`define APF_OFS_CTRL 8'h00
`define APF_OFS_SRC_BASE 8'h04
`define APF_SRC_STRIDE 8'h08
`define APF_OFS_WIN_BASE 8'h1C
`define APF_WIN_STRIDE 8'h04
`define APF_OFS_FLAGS 8'h28
`define APF_OFS_IRQ_STATUS 8'h2C
`define APF_OFS_IRQ_MASK 8'h30

`define APF_CTRL_3D_BIT 0
`define APF_CTRL_DIM_LSB 2
`define APF_CTRL_SDLY_LSB 4
`define APF_CTRL_TDLY_LSB 8
`define APF_CTRL_EDLY_LSB 12

`define APF_WIN_LO_LSB 0
`define APF_WIN_HI_LSB 16

`define APF_IRQ_SRC_BIT 0
`define APF_IRQ_TGT_BIT 1
`define APF_IRQ_END_BIT 2

`define APF_FLAG_SRC_BIT 0
`define APF_FLAG_TGT_BIT 1
`define APF_FLAG_END_BIT 2

`define APF_BOUND_RST 24'h000000
`define APF_WIN_RST 12'h000
`define APF_DELAY_MAX 7

`endif

// ### rtl/apf_pkg.sv
// Types shared by the port/flag block
`default_nettype none
package apf_pkg;
	typedef logic [2:0] apf_delay_t;
	typedef logic [23:0] apf_src_addr_t;
	typedef logic [11:0] apf_tgt_addr_t;
	typedef enum logic [1:0] {
		APF_DIM_COL = 2'h0,
		APF_DIM_ROW = 2'h1,
		APF_DIM_PAGE = 2'h2
	} apf_dim_t;
endpackage
`default_nettype wire

// ### rtl/apf_flag_delay.sv
// Programmable zero to seven cycle delay line for one flag
`default_nettype none
`include "apf_map.svh"
module apf_flag_delay #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic sys_clk_i, // System clock
	input wire logic rst_i, // Async reset, active high
	input wire logic d_i, // Flag at nominal timing
	input wire apf_pkg::apf_delay_t sel_i, // Extra cycles of delay
	output logic q_o // Delayed flag
);
	logic [`APF_DELAY_MAX-1:0] sh_reg;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sh_reg <= {`APF_DELAY_MAX{RST_VAL}};
		end else begin
			sh_reg <= {sh_reg[`APF_DELAY_MAX-2:0], d_i};
		end
	end

	// Zero selects the nominal flop itself, each step adds one stage
	always_comb begin
		if (sel_i == 3'h0) begin
			q_o = d_i;
		end else begin
			q_o = sh_reg[sel_i - 3'h1];
		end
	end
endmodule
`default_nettype wire

// ### rtl/apf_range_check.sv
// Inclusive unsigned bound comparison
`default_nettype none
module apf_range_check #(
	parameter int W = 12
) (
	input wire logic [W-1:0] value_i, // Value under test
	input wire logic [W-1:0] lower_i, // Lowest value inside
	input wire logic [W-1:0] upper_i, // Highest value inside
	output logic inside_o // Value lies within bounds
);
	assign inside_o = (value_i >= lower_i) && (value_i <= upper_i);
endmodule
`default_nettype wire

// ### testbench/apf_img_side.sv
// Image memory and interpolator side of the port and flag block
`default_nettype none
module apf_img_side (
	input wire logic sys_clk_i, // System clock
	input wire logic [23:0] sa_i, // Source address pin data
	input wire logic sa_oe_i, // Source pin drive enable
	input wire logic [7:0] ka_i, // Coef address pin data
	input wire logic ka_oe_i, // Coef pin drive enable
	input wire logic [11:0] ta_i, // Target address pin data
	input wire logic ta_oe_i, // Target pin drive enable
	input wire logic tw_i, // Target strobe pin data
	input wire logic tw_oe_i, // Strobe pin drive enable
	input wire logic src_flag_n_i, // Source flags of all devices
	output logic [23:0] sa_bus_o, // Resolved source bus
	output logic [7:0] ka_bus_o, // Resolved coef bus
	output logic [11:0] ta_bus_o, // Resolved target bus
	output logic tw_line_o, // Resolved strobe, pulled up
	output logic bg_fill_o // Interpolator takes background
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] sa_reg;
	logic [7:0] ka_reg;
	logic [11:0] ta_reg;
	// Released lines show inverted history, never a stale copy
	always_ff @(posedge sys_clk_i) begin
		sa_reg <= sa_bus_o;
		ka_reg <= ka_bus_o;
		ta_reg <= ta_bus_o;
	end
	assign sa_bus_o = sa_oe_i ? sa_i : ~sa_reg;
	assign ka_bus_o = ka_oe_i ? ka_i : ~ka_reg;
	assign ta_bus_o = ta_oe_i ? ta_i : ~ta_reg;
	assign tw_line_o = tw_oe_i ? tw_i : 1'b1;
	// One device here, so the OR of flags is just its own
	assign bg_fill_o = src_flag_n_i;
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench of the port and flag block
`default_nettype none
`include "apf_map.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata_o, q;
	logic pready_o, pslverr_o, e, soe_n = 1, koe_n = 1, toe_n = 1;
	logic [23:0] sa_i = 24'h0, coord = 24'h0, sa_o, sa_b;
	logic [7:0] ka_i = 8'h00, ka_o, ka_b;
	logic [11:0] ta_i = 12'h000, tc = 12'h000, tr = 12'h000, tp = 12'h000;
	logic [11:0] ta_o, ta_b;
	logic tw_i = 1, wl = 0, tw_o, tw_b, sa_oe, ka_oe, ta_oe, tw_oe;
	logic sflag, tflag, eflag, irq_o, bg;
	logic [31:0] seed = 32'hFFF7;
	int bad_count = 0, cmp_count = 0, slo[3], shi[3], wlo[3], whi[3];
	int hs[9], ht[9], he[9], pa, pk, pt, pw;
	always #4 sys_clk_i = ~sys_clk_i;
	apf_port_flags dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.paddr_i(paddr), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o),
		.src_port_oe_n_i(soe_n), .coef_port_oe_n_i(koe_n),
		.tgt_port_oe_n_i(toe_n), .source_address_i(sa_i),
		.coefficient_address_i(ka_i), .target_address_i(ta_i),
		.target_write_n_i(tw_i), .src_coord_i(coord), .tgt_col_i(tc),
		.tgt_row_i(tr), .tgt_page_i(tp), .walk_last_i(wl),
		.source_address_o(sa_o), .source_address_oe_o(sa_oe),
		.coefficient_address_o(ka_o), .coefficient_address_oe_o(ka_oe),
		.target_address_o(ta_o), .target_address_oe_o(ta_oe),
		.target_write_n_o(tw_o), .target_write_oe_o(tw_oe),
		.source_in_range_n_o(sflag), .target_in_window_n_o(tflag),
		.dimension_last_walk_o(eflag), .irq_o(irq_o));
	apf_img_side mem (.sys_clk_i(sys_clk_i), .sa_i(sa_o), .sa_oe_i(sa_oe),
		.ka_i(ka_o), .ka_oe_i(ka_oe), .ta_i(ta_o), .ta_oe_i(ta_oe),
		.tw_i(tw_o), .tw_oe_i(tw_oe), .src_flag_n_i(sflag),
		.sa_bus_o(sa_b), .ka_bus_o(ka_b), .ta_bus_o(ta_b),
		.tw_line_o(tw_b), .bg_fill_o(bg));
	function automatic int rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return int'(seed & 32'h7FFFFFFF);
	endfunction
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_i);
		penable <= 1;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		q = prdata_o;
		e = pslverr_o;
		psel <= 0;
		penable <= 0;
		if (n >= 50) begin
			bad_count++;
			$display("CHECK FAILED %0t no ready", $time);
			finish_test();
		end
	endtask
	function automatic int inw(input logic [11:0] v, input int i);
		return int'(v) >= wlo[i] && int'(v) <= whi[i];
	endfunction
	initial begin
		#160000;
		bad_count++;
		finish_test();
	end
	initial begin
		int dim, di, td, ds, dt, de, c, sp;
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 0;
		apb(0, `APF_OFS_CTRL, 0);
		chk(q, 0, "ctrl reset");
		apb(0, `APF_OFS_WIN_BASE, 0);
		chk(q, 0, "window reset");
		apb(0, 8'h40, 0);
		chk({e, q[30:0]}, 32'h80000000, "unmapped");
		$display("test reset done");
		for (int d = 0; d < 8; d++) begin
			// Every dimension code, with and without pages
			dim = d % 4;
			di = (dim == 3) ? 0 : dim;
			td = d / 4;
			ds = d;
			dt = (d + 3) % 8;
			de = 7 - d;
			for (int i = 0; i < 3; i++) begin
				slo[i] = (rnd() & 32'h7FFF00) + 1;
				shi[i] = slo[i] + rnd() % 64 + 1;
				// Top bit of window set at times: compare is unsigned
				wlo[i] = (rnd() & 32'hEF0) + 1;
				whi[i] = wlo[i] + rnd() % 32 + 1;
				apb(1, `APF_OFS_SRC_BASE + 8'(i) * `APF_SRC_STRIDE, slo[i]);
				apb(1, `APF_OFS_SRC_BASE + 8'(i) * `APF_SRC_STRIDE + 8'h04,
					shi[i]);
				apb(1, `APF_OFS_WIN_BASE + 8'(i) * `APF_WIN_STRIDE,
					(whi[i] << `APF_WIN_HI_LSB) | wlo[i]);
			end
			apb(1, `APF_OFS_CTRL, td | (dim << `APF_CTRL_DIM_LSB) |
				(ds << `APF_CTRL_SDLY_LSB) | (dt << `APF_CTRL_TDLY_LSB) |
				(de << `APF_CTRL_EDLY_LSB));
			for (c = 0; c < 40; c++) begin
				@(posedge sys_clk_i);
				for (int k = 8; k > 0; k--) begin
					hs[k] = hs[k-1];
					ht[k] = ht[k-1];
					he[k] = he[k-1];
				end
				hs[0] = !(int'(coord) >= slo[di] && int'(coord) <= shi[di]);
				ht[0] = !(inw(tc, 0) && inw(tr, 1) && (!td || inw(tp, 2)));
				he[0] = wl;
				pa = sa_i;
				pk = ka_i;
				pt = ta_i;
				pw = tw_i;
				sp = shi[di] - slo[di];
				coord <= 24'(slo[di] - 1 + rnd() % (sp + 3));
				tc <= 12'(wlo[0] - 1 + rnd() % (whi[0] - wlo[0] + 3));
				tr <= 12'(wlo[1] - 1 + rnd() % (whi[1] - wlo[1] + 3));
				tp <= 12'(wlo[2] - 1 + rnd() % (whi[2] - wlo[2] + 3));
				wl <= rnd() % 4 == 0;
				{soe_n, koe_n, toe_n, tw_i} <= 4'(rnd());
				sa_i <= 24'(rnd());
				ka_i <= 8'(rnd());
				ta_i <= 12'(rnd());
				#1;
				if (c > 8) begin
					chk(sflag, hs[ds], "source flag");
					chk(tflag, ht[dt], "target flag");
					chk(eflag, he[de], "last walk flag");
				end
				chk({sa_oe, ka_oe, ta_oe, tw_oe},
					{~soe_n, ~koe_n, ~toe_n, ~toe_n}, "enables");
				if (!soe_n)
					chk(sa_b, pa, "source bus");
				if (!koe_n)
					chk(ka_b, pk, "coef bus");
				if (!toe_n)
					chk({tw_b, ta_b}, (pw << 12) | pt, "target bus");
				else
					chk(tw_b, 1, "strobe released");
			end
			$display("test flags delay %0d done", d);
		end
		@(posedge sys_clk_i);
		coord <= 24'(slo[0]);
		tc <= 12'(wlo[0]);
		tr <= 12'(wlo[1]);
		wl <= 0;
		apb(1, `APF_OFS_CTRL, 0);
		apb(1, `APF_OFS_IRQ_MASK, 0);
		repeat (3) @(posedge sys_clk_i);
		apb(0, `APF_OFS_IRQ_STATUS, 0);
		coord <= 24'(shi[0] + 1);
		tc <= 12'(wlo[0] - 1);
		wl <= 1;
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk(irq_o, 0, "masked irq");
		apb(1, `APF_OFS_IRQ_MASK, 1);
		@(posedge sys_clk_i);
		#1;
		chk(irq_o, 1, "irq raised");
		apb(0, `APF_OFS_IRQ_STATUS, 0);
		chk(q, 7, "status");
		@(posedge sys_clk_i);
		#1;
		chk(irq_o, 0, "irq cleared");
		apb(0, `APF_OFS_FLAGS, 0);
		chk(q, 7, "flags reg");
		chk(bg, 1, "background fill");
		apb(0, `APF_OFS_IRQ_MASK, 0);
		chk(q, 1, "mask reg");
		$display("test irq done");
		finish_test();
	end
endmodule
`default_nettype wire
